// [rtl/rfc_map.svh]
// Purpose: Register offsets, field positions, reset values and CRC constants.
// Assumes: Included by bare name; definitions only.
// Notes:   Presets are stored LSB-aligned in a 16-bit word.
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RFC_OFS_TX_CRC 8'h2C
`define RFC_OFS_RX_CRC 8'h2D
`define RFC_OFS_TX_BITS 8'h2E
`define RFC_OFS_PULSE 8'h2F
`define RFC_OFS_STATUS 8'h3E
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFC_CRC_ON_BIT 0
`define RFC_CRC_INV_BIT 1
`define RFC_CRC_KIND_LSB 2
`define RFC_CRC_SEL_LSB 4
`define RFC_RX_FWD_BIT 7
`define RFC_LASTBITS_LSB 0
`define RFC_PAYLOAD_BIT 3
`define RFC_GRID_BIT 4
`define RFC_STAT_ERR_BIT 0
`define RFC_STAT_BUSY_BIT 1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RFC_RST_TX_CRC 7'h00
`define RFC_RST_RX_CRC 8'h00
`define RFC_RST_TX_BITS 5'h00
`define RFC_RST_PULSE 8'h00
// ----------------------------------------
// CRC shapes (reflected polynomials, LSB first)
// ----------------------------------------
`define RFC_POLY16 16'h8408
`define RFC_POLY8 8'hB8
`define RFC_POLY5 5'h14
`define RFC_W16 5'h10
`define RFC_W8 5'h08
`define RFC_W5 5'h05
`define RFC_P16_1 16'h6363
`define RFC_P16_2 16'hA671
`define RFC_P16_3 16'hFFFE
`define RFC_P16_7 16'hFFFF
`define RFC_P8_1 8'h12
`define RFC_P8_2 8'hBF
`define RFC_P8_3 8'hFD
`define RFC_P8_7 8'hFF
`define RFC_P5_1 5'h12
`define RFC_P5_7 5'h1F
// ----------------------------------------
// Timing
// ----------------------------------------
`define RFC_ETU_CLOCKS 16'h0080
`endif

// [rtl/rfc_pkg.sv]
// Purpose: Types shared by the CRC and transmit bit configuration block.
// Assumes: Widths fixed here; module parameters stay within them.
// Notes:   One packed struct carries all state of the top module except the two reset release flops.
package rfc_pkg;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_WAIT = 3'b001,
        TX_SOF = 3'b010,
        TX_DATA = 3'b011,
        TX_CRC = 3'b100,
        TX_EOF = 3'b101
    } rfc_tx_state_type;

    typedef enum logic [1:0] {
        CRC_K5 = 2'b00,
        CRC_K8 = 2'b01,
        CRC_K16 = 2'b10,
        CRC_KRES = 2'b11
    } rfc_crc_kind_type;

    typedef struct packed {
        logic [15:0] crc16;
        logic [7:0] crc8;
        logic [4:0] crc5;
    } rfc_user_preset_type;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rfc_tx_byte_type;

    typedef struct packed {
        logic start;
        logic valid;
        logic value;
        logic fin;
    } rfc_rx_bit_type;

    typedef struct packed {
        logic [7:0] rdata;
        logic [6:0] tx_crc;
        logic [7:0] rx_crc;
        logic [4:0] tx_bits;
        logic [7:0] pulse_w;
        logic crc_err;
        rfc_tx_state_type st;
        logic [15:0] etu_cnt;
        logic cur_bit;
        logic [7:0] sr;
        logic [3:0] bits_left;
        logic cur_last;
        logic [7:0] nb;
        logic nb_last;
        logic have_nb;
        logic got_last;
        logic ready;
        logic [15:0] tcrc;
        logic [15:0] tsr;
        logic [4:0] tleft;
        logic mod;
        logic busy;
        logic [15:0] rcrc;
        logic [15:0] hist;
        logic [4:0] hcnt;
        logic [7:0] acc;
        logic [3:0] acc_cnt;
        logic fifo_wr;
        logic [7:0] fifo_data;
    } rfc_state_type;
endpackage

// [rtl/rfc_frame_top.sv]
// Purpose: CRC handling and transmit bit shaping for RF frames.
// Assumes: Clock is the carrier-derived system clock; inputs synchronous.
// Notes:   Register port with read data one cycle after the read strobe.
//
// What this block does
// - Tx preset code loads CRC start value
// - Rx preset code uses same value table
// - Code 6 takes stored user start value
// - Forward bit copies received CRC to FIFO
// - Rx kind field selects CRC5, CRC8, CRC16
// - Rx invert checks against complemented CRC
// - Check enable gates error flag setting
// - Grid bit aligns starts to ETU boundaries
// - Payload bit off sends one symbol
// - Final byte bit count, zero means eight
// - LSB first; truncation drops top bits
// - Pulse lasts programmed width plus one
// - Pulse cut at end of bit
// - Pulse start from separate placement input
// - Width applies only with Miller selected
// - Width also shapes start and stop symbols
// - Tx enable appends CRC after data
// - Tx invert complements appended CRC
// - Tx preset field selects outgoing start value
`include "rfc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rfc_frame_top #(
    parameter logic [15:0] ETU_CLOCKS = `RFC_ETU_CLOCKS
) (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire rfc_pkg::rfc_user_preset_type I_USER_PRESET,
    input wire logic I_MILLER_SEL,
    input wire logic [7:0] I_PULSE_START,
    input wire logic I_TX_START,
    input wire logic I_TX_VALID,
    input wire rfc_pkg::rfc_tx_byte_type I_TX_BYTE,
    output logic O_TX_READY,
    output logic O_TX_MOD,
    output logic O_TX_BUSY,
    input wire rfc_pkg::rfc_rx_bit_type I_RX,
    output logic O_FIFO_WR,
    output logic [7:0] O_FIFO_DATA,
    output logic O_CRC_ERR
);
    import rfc_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // CRC helpers
    // ----------------------------------------
    function automatic logic [4:0] crc_width(input rfc_crc_kind_type k);
        case (k)
            CRC_K16: crc_width = `RFC_W16;
            CRC_K8: crc_width = `RFC_W8;
            CRC_K5: crc_width = `RFC_W5;
            default: crc_width = 5'h00;
        endcase
    endfunction

    function automatic logic [15:0] crc_mask(input rfc_crc_kind_type k);
        case (k)
            CRC_K16: crc_mask = 16'hFFFF;
            CRC_K8: crc_mask = 16'h00FF;
            CRC_K5: crc_mask = 16'h001F;
            default: crc_mask = 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] crc_step(input rfc_crc_kind_type k, input logic [15:0] c,
                                             input logic b);
        logic fb;
        logic [15:0] n;
        fb = c[0] ^ b;
        n = {1'b0, c[15:1]};
        case (k)
            CRC_K16: n = fb ? (n ^ `RFC_POLY16) : n;
            CRC_K8: n = fb ? (n ^ {8'h00, `RFC_POLY8}) : n;
            CRC_K5: n = fb ? (n ^ {11'h000, `RFC_POLY5}) : n;
            default: n = c;
        endcase
        crc_step = n & crc_mask(k);
    endfunction

    // Undefined codes (4, 5, and 2, 3 for CRC5) start from zero
    function automatic logic [15:0] crc_preset(input rfc_crc_kind_type k, input logic [2:0] sel,
                                               input rfc_user_preset_type up);
        crc_preset = 16'h0000;
        case (k)
            CRC_K16: begin
                case (sel)
                    3'h1: crc_preset = `RFC_P16_1;
                    3'h2: crc_preset = `RFC_P16_2;
                    3'h3: crc_preset = `RFC_P16_3;
                    3'h6: crc_preset = up.crc16;
                    3'h7: crc_preset = `RFC_P16_7;
                    default: crc_preset = 16'h0000;
                endcase
            end
            CRC_K8: begin
                case (sel)
                    3'h1: crc_preset = {8'h00, `RFC_P8_1};
                    3'h2: crc_preset = {8'h00, `RFC_P8_2};
                    3'h3: crc_preset = {8'h00, `RFC_P8_3};
                    3'h6: crc_preset = {8'h00, up.crc8};
                    3'h7: crc_preset = {8'h00, `RFC_P8_7};
                    default: crc_preset = 16'h0000;
                endcase
            end
            CRC_K5: begin
                case (sel)
                    3'h1: crc_preset = {11'h000, `RFC_P5_1};
                    3'h6: crc_preset = {11'h000, up.crc5};
                    3'h7: crc_preset = {11'h000, `RFC_P5_7};
                    default: crc_preset = 16'h0000;
                endcase
            end
            default: crc_preset = 16'h0000;
        endcase
    endfunction

    // ----------------------------------------
    // State and field views
    // ----------------------------------------
    rfc_state_type s_r;
    rfc_state_type s_nxt;

    rfc_crc_kind_type tx_kind;
    rfc_crc_kind_type rx_kind;
    logic [2:0] tx_sel;
    logic [2:0] rx_sel;
    logic [4:0] tx_w;
    logic [4:0] rx_w;
    logic [2:0] last_cnt;
    logic [15:0] tx_final;
    logic [15:0] rx_got;
    logic [15:0] rx_calc;
    logic [3:0] pop_idx;
    logic rx_pop;
    logic [15:0] pulse_end;
    logic etu_wrap;

    assign tx_kind = rfc_crc_kind_type'(s_r.tx_crc[`RFC_CRC_KIND_LSB +: 2]);
    assign rx_kind = rfc_crc_kind_type'(s_r.rx_crc[`RFC_CRC_KIND_LSB +: 2]);
    assign tx_sel = s_r.tx_crc[`RFC_CRC_SEL_LSB +: 3];
    assign rx_sel = s_r.rx_crc[`RFC_CRC_SEL_LSB +: 3];
    assign tx_w = crc_width(tx_kind);
    assign rx_w = crc_width(rx_kind);
    assign last_cnt = s_r.tx_bits[`RFC_LASTBITS_LSB +: 3];
    assign tx_final = s_r.tcrc ^ (s_r.tx_crc[`RFC_CRC_INV_BIT] ? crc_mask(tx_kind) : 16'h0000);
    assign pop_idx = 4'(5'h10 - rx_w);
    assign rx_pop = s_r.hist[pop_idx];
    assign rx_got = s_r.hist >> (5'h10 - rx_w);
    assign rx_calc = s_r.rcrc ^ (s_r.rx_crc[`RFC_CRC_INV_BIT] ? crc_mask(rx_kind) : 16'h0000);
    assign pulse_end = {8'h00, I_PULSE_START} + {8'h00, s_r.pulse_w} + 16'h0001;
    assign etu_wrap = (s_r.etu_cnt == ETU_CLOCKS - 16'h0001);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        s_nxt.fifo_wr = 1'b0;

        // Register port
        if (I_WR) begin
            case (I_ADDR)
                `RFC_OFS_TX_CRC: s_nxt.tx_crc = I_WDATA[6:0];
                `RFC_OFS_RX_CRC: s_nxt.rx_crc = I_WDATA;
                `RFC_OFS_TX_BITS: s_nxt.tx_bits = I_WDATA[4:0];
                `RFC_OFS_PULSE: s_nxt.pulse_w = I_WDATA;
                `RFC_OFS_STATUS: begin
                    if (I_WDATA[`RFC_STAT_ERR_BIT]) begin
                        s_nxt.crc_err = 1'b0;
                    end
                end
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        if (I_RD) begin
            case (I_ADDR)
                `RFC_OFS_TX_CRC: s_nxt.rdata = {1'b0, s_r.tx_crc};
                `RFC_OFS_RX_CRC: s_nxt.rdata = s_r.rx_crc;
                `RFC_OFS_TX_BITS: s_nxt.rdata = {3'h0, s_r.tx_bits};
                `RFC_OFS_PULSE: s_nxt.rdata = s_r.pulse_w;
                `RFC_OFS_STATUS: s_nxt.rdata = {6'h00, s_r.busy, s_r.crc_err};
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // Bit timing: free-running ETU counter
        s_nxt.etu_cnt = etu_wrap ? 16'h0000 : s_r.etu_cnt + 16'h0001;

        // Byte intake; only while the holding slot is empty
        if (I_TX_VALID && s_r.ready) begin
            s_nxt.nb = I_TX_BYTE.data;
            s_nxt.nb_last = I_TX_BYTE.last;
            s_nxt.have_nb = 1'b1;
            s_nxt.got_last = I_TX_BYTE.last;
        end

        case (s_r.st)
            TX_IDLE: begin
                s_nxt.cur_bit = 1'b0;
                if (I_TX_START) begin
                    s_nxt.tcrc = crc_preset(tx_kind, tx_sel, I_USER_PRESET);
                    s_nxt.cur_last = 1'b0;
                    s_nxt.bits_left = 4'h0;
                    s_nxt.have_nb = 1'b0;
                    s_nxt.got_last = 1'b0;
                    s_nxt.st = TX_WAIT;
                    // Free start: restart the bit grid
                    if (!s_r.tx_bits[`RFC_GRID_BIT]) begin
                        s_nxt.etu_cnt = ETU_CLOCKS - 16'h0001;
                    end
                end
            end
            TX_WAIT: begin
                if (etu_wrap) begin
                    s_nxt.cur_bit = 1'b1;
                    s_nxt.st = TX_SOF;
                end
            end
            TX_SOF, TX_DATA: begin
                if (etu_wrap) begin
                    if (s_r.st == TX_SOF && !s_r.tx_bits[`RFC_PAYLOAD_BIT]) begin
                        s_nxt.cur_bit = 1'b0;
                        s_nxt.st = TX_IDLE;
                    end else if (s_r.bits_left != 4'h0) begin
                        s_nxt.cur_bit = s_r.sr[0];
                        s_nxt.sr = {1'b0, s_r.sr[7:1]};
                        s_nxt.bits_left = s_r.bits_left - 4'h1;
                        s_nxt.tcrc = crc_step(tx_kind, s_r.tcrc, s_r.sr[0]);
                        s_nxt.st = TX_DATA;
                    end else if (!s_r.cur_last && s_r.have_nb) begin
                        s_nxt.cur_bit = s_r.nb[0];
                        s_nxt.sr = {1'b0, s_r.nb[7:1]};
                        // Short final byte drops its upper bits
                        s_nxt.bits_left = (s_r.nb_last && last_cnt != 3'h0) ?
                                          {1'b0, last_cnt - 3'h1} : 4'h7;
                        s_nxt.cur_last = s_r.nb_last;
                        s_nxt.have_nb = 1'b0;
                        s_nxt.tcrc = crc_step(tx_kind, s_r.tcrc, s_r.nb[0]);
                        s_nxt.st = TX_DATA;
                    end else if (s_r.tx_crc[`RFC_CRC_ON_BIT] && tx_w != 5'h00) begin
                        s_nxt.cur_bit = tx_final[0];
                        s_nxt.tsr = {1'b0, tx_final[15:1]};
                        s_nxt.tleft = tx_w - 5'h01;
                        s_nxt.st = TX_CRC;
                    end else begin
                        s_nxt.cur_bit = 1'b1;
                        s_nxt.st = TX_EOF;
                    end
                end
            end
            TX_CRC: begin
                if (etu_wrap) begin
                    if (s_r.tleft != 5'h00) begin
                        s_nxt.cur_bit = s_r.tsr[0];
                        s_nxt.tsr = {1'b0, s_r.tsr[15:1]};
                        s_nxt.tleft = s_r.tleft - 5'h01;
                    end else begin
                        s_nxt.cur_bit = 1'b1;
                        s_nxt.st = TX_EOF;
                    end
                end
            end
            TX_EOF: begin
                if (etu_wrap) begin
                    s_nxt.cur_bit = 1'b0;
                    s_nxt.st = TX_IDLE;
                end
            end
            default: begin
                s_nxt.st = TX_IDLE;
            end
        endcase

        s_nxt.busy = (s_nxt.st != TX_IDLE);
        s_nxt.ready = (s_nxt.st == TX_WAIT || s_nxt.st == TX_SOF || s_nxt.st == TX_DATA) &&
                      s_r.tx_bits[`RFC_PAYLOAD_BIT] && !s_nxt.have_nb && !s_nxt.got_last;

        // Modulation: pulse kept inside the current bit
        if (s_nxt.st == TX_IDLE || s_nxt.st == TX_WAIT) begin
            s_nxt.mod = 1'b0;
        end else if (I_MILLER_SEL) begin
            s_nxt.mod = s_nxt.cur_bit &&
                        s_nxt.etu_cnt >= {8'h00, I_PULSE_START} &&
                        s_nxt.etu_cnt < pulse_end;
        end else begin
            s_nxt.mod = s_nxt.cur_bit;
        end

        // Receive: newest CRC-width bits wait in hist,
        // so the checksum skips the CRC field
        if (I_RX.start) begin
            s_nxt.rcrc = crc_preset(rx_kind, rx_sel, I_USER_PRESET);
            s_nxt.hcnt = 5'h00;
            s_nxt.acc_cnt = 4'h0;
            s_nxt.hist = 16'h0000;
        end else if (I_RX.valid) begin
            s_nxt.hist = {I_RX.value, s_r.hist[15:1]};
            if (rx_w != 5'h00 && s_r.hcnt == rx_w) begin
                s_nxt.rcrc = crc_step(rx_kind, s_r.rcrc, rx_pop);
            end else if (rx_w != 5'h00) begin
                s_nxt.hcnt = s_r.hcnt + 5'h01;
            end
            // Forward all bits, else only those leaving hist
            if (s_r.rx_crc[`RFC_RX_FWD_BIT] || rx_w == 5'h00 || s_r.hcnt == rx_w) begin
                s_nxt.acc = {(s_r.rx_crc[`RFC_RX_FWD_BIT] || rx_w == 5'h00) ?
                             I_RX.value : rx_pop, s_r.acc[7:1]};
                s_nxt.acc_cnt = s_r.acc_cnt + 4'h1;
                if (s_r.acc_cnt == 4'h7) begin
                    s_nxt.fifo_wr = 1'b1;
                    s_nxt.fifo_data = s_nxt.acc;
                    s_nxt.acc_cnt = 4'h0;
                end
            end
        end else if (I_RX.fin) begin
            // Unaligned tail lands LSB-aligned in one more FIFO byte
            if (s_r.acc_cnt != 4'h0) begin
                s_nxt.fifo_wr = 1'b1;
                s_nxt.fifo_data = s_r.acc >> (4'h8 - s_r.acc_cnt);
                s_nxt.acc_cnt = 4'h0;
            end
            if (s_r.rx_crc[`RFC_CRC_ON_BIT] && rx_w != 5'h00 &&
                (s_r.hcnt != rx_w || rx_got != rx_calc)) begin
                s_nxt.crc_err = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge I_CLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r <= '0;
            s_r.tx_crc <= `RFC_RST_TX_CRC;
            s_r.rx_crc <= `RFC_RST_RX_CRC;
            s_r.tx_bits <= `RFC_RST_TX_BITS;
            s_r.pulse_w <= `RFC_RST_PULSE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign O_RDATA = s_r.rdata;
    assign O_TX_READY = s_r.ready;
    assign O_TX_MOD = s_r.mod;
    assign O_TX_BUSY = s_r.busy;
    assign O_FIFO_WR = s_r.fifo_wr;
    assign O_FIFO_DATA = s_r.fifo_data;
    assign O_CRC_ERR = s_r.crc_err;

endmodule

`default_nettype wire

// [dv/rfc_frame_assertions.sv]
// Purpose: Port-level checks of the CRC and transmit bit block.
// Assumes: One clock; all checks off while I_NRST is low.
// Notes: Pulse run check needs a nonzero pulse start.
`timescale 1ns/1ps
`default_nettype none
module rfc_frame_assertions #(
    parameter logic [15:0] ETU_CLOCKS = 16'h0080
) (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic I_MILLER_SEL,
    input wire logic [7:0] I_PULSE_START,
    input wire logic I_TX_START,
    input wire logic I_TX_VALID,
    input wire logic O_TX_READY,
    input wire logic O_TX_MOD,
    input wire logic O_TX_BUSY,
    input wire rfc_pkg::rfc_rx_bit_type I_RX,
    input wire logic O_FIFO_WR,
    input wire logic O_CRC_ERR
);
    logic [8:0] run_r;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    // Length of the current high run of the modulation output
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            run_r <= 9'h000;
        end else begin
            run_r <= O_TX_MOD ? run_r + 9'h001 : 9'h000;
        end
    end
    chk_rdata_quiet: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside its cycle");
    chk_err_from_fin: assert property ($rose(O_CRC_ERR) |-> $past(I_RX.fin) || $past(I_RX.fin, 2))
        else $error("error flag rose without frame end");
    chk_err_sticky: assert property (O_CRC_ERR && !(I_WR && I_ADDR == 8'h3E && I_WDATA[0])
        |=> O_CRC_ERR)
        else $error("error flag lost");
    chk_fifo_cause: assert property (O_FIFO_WR |-> $past(I_RX.valid) || $past(I_RX.fin)
        || $past(I_RX.valid, 2) || $past(I_RX.fin, 2))
        else $error("fifo write without received bit");
    chk_busy_follows: assert property (I_TX_START && !O_TX_BUSY |=> O_TX_BUSY)
        else $error("frame start not taken");
    chk_ready_in_frame: assert property (O_TX_READY |-> O_TX_BUSY)
        else $error("ready outside frame");
    chk_byte_taken: assert property (I_TX_VALID && O_TX_READY |=> !O_TX_READY)
        else $error("ready held after byte taken");
    chk_idle_quiet: assert property (!O_TX_BUSY && !$past(O_TX_BUSY) |-> !O_TX_MOD)
        else $error("modulation outside frame");
    chk_frame_bounded: assert property ($rose(O_TX_BUSY) |-> ##[1:1000] !O_TX_BUSY)
        else $error("frame never ends");
    chk_pulse_in_bit: assert property (I_MILLER_SEL && I_PULSE_START != 8'h00
        |-> run_r <= ETU_CLOCKS[8:0])
        else $error("pulse longer than a bit");
    cover property (O_FIFO_WR);
    cover property ($rose(O_CRC_ERR));
    cover property (I_MILLER_SEL && $rose(O_TX_MOD));
endmodule
bind rfc_frame_top rfc_frame_assertions #(.ETU_CLOCKS(ETU_CLOCKS)) chk_u (.*);
`default_nettype wire

// [dv/rfc_card_model.sv]
// Purpose: Card side: sends frames, decodes reader frames.
// Assumes: Decoding only with pulse shaping off (level per bit).
// Notes: Samples mid-bit, tolerating small edge shifts.
`timescale 1ns/1ps
`default_nettype none
module rfc_card_model #(
    parameter int ETU = 8
) (
    input wire logic clk,
    input wire logic start,
    input wire logic busy,
    input wire logic mod,
    output var rfc_pkg::rfc_rx_bit_type rx
);
    import rfc_pkg::*;
    logic got[$];
    initial rx = '0;
    task automatic send(input logic [31:0] b, input int n);
        @(posedge clk);
        rx <= 4'b1000;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx <= {2'b01, b[i], 1'b0};
        end
        @(posedge clk);
        rx <= 4'b0001;
        @(posedge clk);
        rx <= 4'b0000;
    endtask
    always @(posedge clk) begin
        if (start && !busy) begin
            got.delete();
            repeat (2 + ETU / 2) @(posedge clk);
            while (busy) begin
                got.push_back(mod);
                repeat (ETU) @(posedge clk);
            end
        end
    end
endmodule
`default_nettype wire

// [dv/rfc_frame_top_tb.sv]
// Purpose: Self-checking bench: registers, transmit frames, receive CRC.
// Assumes: Short bit period; pulse start offset fixed at one clock.
// Notes: Expected CRCs computed bit by bit.
`include "rfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rfc_frame_top_tb;
    import rfc_pkg::*;
    localparam int ETU = 8;
    localparam logic [39:0] TX[18] = '{40'h1908B20000, 40'h0908B20000, 40'h2908B20000,
        40'h3908B20000, 40'h6908B20000, 40'h7908B20000, 40'h1B08B20000, 40'h2508B20000,
        40'h3508B20000, 40'h6508B20000, 40'h7108B20000, 40'h6108B20000, 40'h1D08B20000,
        40'h000BB20000, 40'h000EB20000, 40'h1900B20000, 40'h0000000102, 40'h00100001FF};
    localparam logic [31:0] RX[8] = '{32'h19000100, 32'h99000300, 32'h19010101,
        32'h18010100, 32'h1B020100, 32'h1B000101, 32'h65000100, 32'hF1000200};
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, start = 1'b0, valid = 1'b0;
    logic miller = 1'b0, ready, mod, busy, fwr, err;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, fdata, v;
    rfc_user_preset_type up = {16'h1234, 8'h5A, 5'h0B};
    rfc_tx_byte_type txb = '0;
    rfc_rx_bit_type rx;
    int num_errors = 0, checks_done = 0, nfifo = 0, hi = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        nfifo <= nfifo + int'(fwr);
        hi <= hi + int'(mod);
    end
    rfc_frame_top #(.ETU_CLOCKS(16'(ETU))) dut_u (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_USER_PRESET(up),
        .I_MILLER_SEL(miller), .I_PULSE_START(8'h01), .I_TX_START(start),
        .I_TX_VALID(valid), .I_TX_BYTE(txb), .O_TX_READY(ready), .O_TX_MOD(mod),
        .O_TX_BUSY(busy), .I_RX(rx), .O_FIFO_WR(fwr), .O_FIFO_DATA(fdata), .O_CRC_ERR(err));
    rfc_card_model #(.ETU(ETU)) card_u (.clk(clk), .start(start), .busy(busy), .mod(mod),
        .rx(rx));
    task automatic end_sim;
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    // Reflected shift, LSB of data first
    function automatic logic [15:0] crc_of(input logic [1:0] k, input logic [15:0] c,
        input logic [7:0] d, input int n);
        logic [15:0] p;
        p = k == 2'd2 ? 16'h8408 : k == 2'd1 ? 16'h00B8 : 16'h0014;
        for (int i = 0; i < n; i++) begin
            c = (c[0] ^ d[i]) ? (c >> 1) ^ p : c >> 1;
        end
        return c;
    endfunction
    function automatic logic [15:0] pre(input logic [1:0] k, input logic [2:0] s);
        case (s)
            3'h1: pre = k == 2'd2 ? 16'h6363 : 16'h0012;
            3'h2: pre = k == 2'd2 ? 16'hA671 : k == 2'd1 ? 16'h00BF : 16'h0000;
            3'h3: pre = k == 2'd2 ? 16'hFFFE : k == 2'd1 ? 16'h00FD : 16'h0000;
            3'h6: pre = k == 2'd2 ? up.crc16 : k == 2'd1 ? {8'h00, up.crc8} : {11'h0, up.crc5};
            3'h7: pre = k == 2'd2 ? 16'hFFFF : k == 2'd1 ? 16'h00FF : 16'h001F;
            default: pre = 16'h0000;
        endcase
    endfunction
    task automatic tx_frame(input logic [39:0] e);
        logic [15:0] c;
        logic q[$];
        int n, w, h0, ones;
        n = e[26:24] == 3'd0 ? 8 : int'(e[26:24]);
        w = e[35:34] == 2'd2 ? 16 : e[35:34] == 2'd1 ? 8 : 5;
        wr_reg(`RFC_OFS_TX_CRC, e[39:32]);
        wr_reg(`RFC_OFS_TX_BITS, e[31:24]);
        wr_reg(`RFC_OFS_PULSE, e[7:0]);
        c = crc_of(e[35:34], pre(e[35:34], e[38:36]), e[23:16], n) ^ {16{e[33]}};
        q.push_back(1'b1);
        if (e[27]) begin
            for (int i = 0; i < n; i++) q.push_back(e[16 + i]);
            if (e[32] && e[35:34] != 2'd3) for (int i = 0; i < w; i++) q.push_back(c[i]);
            q.push_back(1'b1);
        end
        ones = 0;
        foreach (q[i]) ones += int'(q[i]);
        h0 = hi;
        miller <= e[8];
        txb <= '{data: e[23:16], last: 1'b1};
        valid <= e[27];
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 600 && (busy || i == 0); i++) begin
            @(posedge clk);
            if (valid && ready) valid <= 1'b0;
        end
        repeat (2 * ETU) @(posedge clk);
        chk(hi - h0, ones * (!e[8] ? ETU : e[7:0] < ETU - 2 ? e[7:0] + 1 : ETU - 1));
        if (!e[8]) begin
            chk(card_u.got.size(), q.size());
            foreach (q[i]) chk(card_u.got[i], q[i]);
        end
    endtask
    task automatic rx_frame(input logic [31:0] e);
        logic [15:0] c;
        int w, f0;
        w = e[27:26] == 2'd2 ? 16 : e[27:26] == 2'd1 ? 8 : 5;
        c = crc_of(e[27:26], pre(e[27:26], e[30:28]), 8'hA5, 8);
        if (e[17]) c = c ^ 16'((1 << w) - 1);
        wr_reg(`RFC_OFS_STATUS, 8'h01);
        wr_reg(`RFC_OFS_RX_CRC, e[31:24]);
        f0 = nfifo;
        card_u.send({8'h00, c, 8'hA5} ^ (e[16] ? 32'h100 : 32'h0), 8 + w);
        repeat (4) @(posedge clk);
        chk(nfifo - f0, e[15:8]);
        if (!e[31]) chk(fdata, 8'hA5);
        rd_reg(`RFC_OFS_STATUS);
        chk(v, e[7:0]);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 8'h2C; a < 8'h30; a++) begin
            rd_reg(8'(a));
            chk(v, 8'h00);
            wr_reg(8'(a), 8'hFF);
            rd_reg(8'(a));
            chk(v, a == 8'h2C ? 8'h7F : a == 8'h2E ? 8'h1F : 8'hFF);
        end
        wr_reg(8'h10, 8'hFF);
        rd_reg(8'h10);
        chk(v, 8'h00);
        foreach (TX[j]) tx_frame(TX[j]);
        foreach (RX[j]) rx_frame(RX[j]);
        end_sim();
    end
    // Watchdog
    initial begin
        #150us;
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
